// ==== rtl/ccm_cfg.svh ====
// constants for the cpu clock mode controller
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH
// cpu divider field codes
`define CCM_CDIV_1 2'h0
`define CCM_CDIV_2 2'h1
`define CCM_CDIV_4 2'h2
`define CCM_CDIV_16 2'h3
// cpu divider ratios minus one
`define CCM_CPU_DIV1_M1 4'h0
`define CCM_CPU_DIV2_M1 4'h1
`define CCM_CPU_DIV4_M1 4'h3
`define CCM_CPU_DIV8_M1 4'h7
`define CCM_CPU_DIV16_M1 4'hf
// fast oscillator prescaler codes
`define CCM_PRE_DIV2 3'h0
`define CCM_PRE_DIV4 3'h2
`define CCM_PRE_DIV8 3'h6
// fast prescaler ratios minus one
`define CCM_PRE_DIV2_M1 3'h1
`define CCM_PRE_DIV4_M1 3'h3
`define CCM_PRE_DIV8_M1 3'h7
// clock output pin source codes
`define CCM_CLOCK_OUTPUT_PIN_SUB 1'h0
`define CCM_CLOCK_OUTPUT_PIN_PERIPH 1'h1
`endif

// ==== rtl/ccm_pkg.sv ====
// types for the cpu clock mode controller
package ccm_pkg;
  typedef enum logic [2:0] {
    CCM_MODE_MAIN, CCM_MODE_PLL, CCM_MODE_FAST_OCO, CCM_MODE_SLOW_OCO,
    CCM_MODE_SLOW_OCO_LP, CCM_MODE_LOW_SPEED, CCM_MODE_LOW_POWER
  } ccm_mode_e;

  typedef enum logic [2:0] {
    CCM_SRC_MAIN, CCM_SRC_PLL, CCM_SRC_FAST, CCM_SRC_SLOW, CCM_SRC_SUB
  } ccm_src_e;

  typedef struct packed {
    logic div8_select;
    logic [1:0] cpu_divider_field;
    logic pll_select;
    logic onchip_osc_select;
    logic subclock_select;
    logic main_clock_stop;
    logic onchip_osc_choice;
    logic fast_osc_enable;
    logic [2:0] fast_osc_prescaler;
    logic periph_clk_stop_in_wait;
    logic count_source_protect;
  } ccm_ctrl_s;

  // one-cycle enable pulses standing in for the source clocks
  typedef struct packed {
    logic main_clk;
    logic pll_clk;
    logic fast_onchip_raw_clk;
    logic slow_onchip_clk;
    logic sub_clk;
  } ccm_srcs_s;
endpackage

// ==== rtl/ccm_divider.sv ====
// divides a clock enable pulse train by a programmable ratio
`timescale 1ns/10ps
module ccm_divider
  import ccm_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_en,
  input wire logic [W-1:0] ratio_m1,
  output logic tick
);
  logic [W-1:0] cnt_r;

  // terminal count; >= guards against a ratio shrunk mid-period
  assign tick = in_en && (cnt_r >= ratio_m1);

  // period counter, restarts at every tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= '0;
    end else if (in_en) begin
      cnt_r <= cnt_r + W'(1);
    end
  end
endmodule

// ==== rtl/ccm_top.sv ====
// cpu clock mode controller: source select, dividers, wait mode
`timescale 1ns/10ps
`include "ccm_cfg.svh"
module ccm_top
  import ccm_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire ccm_ctrl_s ctrl,
  input wire ccm_srcs_s srcs,
  input wire logic wait_instr,
  input wire logic wake,
  input wire logic clock_output_pin_sel,
  input wire logic [PORT_W-1:0] port_out,
  output logic cpu_clk_en,
  output logic wdt_clk_en,
  output logic periph_clk_main_en,
  output logic fast_onchip_clk_en,
  output logic clock_output_pin,
  output logic [PORT_W-1:0] port_pins,
  output logic in_wait,
  output ccm_mode_e clk_mode
);
  logic in_wait_r;
  logic cpu_clk_en_r;
  logic wdt_clk_en_r;
  logic periph_en_r;
  logic fast_en_r;
  logic clock_output_pin_r;
  logic [PORT_W-1:0] port_r;
  ccm_mode_e mode_r;
  ccm_src_e src_nxt;
  ccm_src_e cur_src_r;
  logic [3:0] ratio_nxt;
  logic [3:0] cur_ratio_r;
  logic [2:0] pre_m1;
  logic fast_tick;
  logic cpu_src_en;
  logic cpu_tick;
  logic f1_tick;
  logic clock_output_pin_run;

  // fast oscillator prescaler; unlisted codes fall back to divide-by-2
  always_comb begin
    case (ctrl.fast_osc_prescaler)
      `CCM_PRE_DIV4: pre_m1 = `CCM_PRE_DIV4_M1;
      `CCM_PRE_DIV8: pre_m1 = `CCM_PRE_DIV8_M1;
      default: pre_m1 = `CCM_PRE_DIV2_M1;
    endcase
  end

  ccm_divider #(.W(3)) u_fast_pre (
    .clock(clock),
    .rst_n(rst_n),
    .in_en(srcs.fast_onchip_raw_clk),
    .ratio_m1(pre_m1),
    .tick(fast_tick)
  );

  // requested source, priority: sub, onchip, pll, main
  always_comb begin
    if (ctrl.subclock_select) begin
      src_nxt = CCM_SRC_SUB;
    end else if (ctrl.onchip_osc_select) begin
      src_nxt = ctrl.onchip_osc_choice ? CCM_SRC_FAST : CCM_SRC_SLOW;
    end else if (ctrl.pll_select) begin
      src_nxt = CCM_SRC_PLL;
    end else begin
      src_nxt = CCM_SRC_MAIN;
    end
  end

  // requested cpu ratio; sub clock drives the cpu undivided
  always_comb begin
    if (src_nxt == CCM_SRC_SUB) begin
      ratio_nxt = `CCM_CPU_DIV1_M1;
    end else if (ctrl.div8_select) begin
      ratio_nxt = `CCM_CPU_DIV8_M1;
    end else begin
      case (ctrl.cpu_divider_field)
        `CCM_CDIV_2: ratio_nxt = `CCM_CPU_DIV2_M1;
        `CCM_CDIV_4: ratio_nxt = `CCM_CPU_DIV4_M1;
        `CCM_CDIV_16: ratio_nxt = `CCM_CPU_DIV16_M1;
        default: ratio_nxt = `CCM_CPU_DIV1_M1;
      endcase
    end
  end

  // enable of the source that currently feeds the cpu divider
  always_comb begin
    case (cur_src_r)
      CCM_SRC_PLL: cpu_src_en = srcs.pll_clk;
      CCM_SRC_FAST: cpu_src_en = fast_tick;
      CCM_SRC_SLOW: cpu_src_en = srcs.slow_onchip_clk;
      CCM_SRC_SUB: cpu_src_en = srcs.sub_clk;
      default: cpu_src_en = srcs.main_clk;
    endcase
  end

  // f1 follows the non-sub source at divide-by-1
  always_comb begin
    if (ctrl.onchip_osc_select) begin
      f1_tick = ctrl.onchip_osc_choice ? fast_tick : srcs.slow_onchip_clk;
    end else if (ctrl.pll_select) begin
      f1_tick = srcs.pll_clk;
    end else begin
      f1_tick = srcs.main_clk;
    end
  end

  ccm_divider #(.W(4)) u_cpu_div (
    .clock(clock),
    .rst_n(rst_n),
    .in_en(cpu_src_en),
    .ratio_m1(cur_ratio_r),
    .tick(cpu_tick)
  );

  // switch source and ratio only at a period end, so no runt period;
  // the old source must still run, which software ordering ensures
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_src_r <= CCM_SRC_MAIN;
      cur_ratio_r <= `CCM_CPU_DIV8_M1;
    end else if (cpu_tick) begin
      cur_src_r <= src_nxt;
      cur_ratio_r <= ratio_nxt;
    end
  end

  // mode decode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= CCM_MODE_MAIN;
    end else if (ctrl.subclock_select) begin
      if (ctrl.main_clock_stop && !ctrl.fast_osc_enable) begin
        mode_r <= CCM_MODE_LOW_POWER;
      end else begin
        mode_r <= CCM_MODE_LOW_SPEED;
      end
    end else if (ctrl.onchip_osc_select) begin
      if (ctrl.onchip_osc_choice) begin
        mode_r <= CCM_MODE_FAST_OCO;
      end else if (ctrl.main_clock_stop && !ctrl.fast_osc_enable) begin
        mode_r <= CCM_MODE_SLOW_OCO_LP;
      end else begin
        mode_r <= CCM_MODE_SLOW_OCO;
      end
    end else if (ctrl.pll_select) begin
      mode_r <= CCM_MODE_PLL;
    end else begin
      mode_r <= CCM_MODE_MAIN;
    end
  end

  // wait state: only the wait instruction enters, wake leaves first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_wait_r <= 1'b0;
    end else if (wake) begin
      in_wait_r <= 1'b0;
    end else if (wait_instr) begin
      in_wait_r <= 1'b1;
    end
  end

  // gated clock enables
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en_r <= 1'b0;
      wdt_clk_en_r <= 1'b0;
      periph_en_r <= 1'b0;
      fast_en_r <= 1'b0;
    end else begin
      cpu_clk_en_r <= cpu_tick && !in_wait_r;
      wdt_clk_en_r <= cpu_tick &&
                      (!in_wait_r || ctrl.count_source_protect);
      periph_en_r <= f1_tick &&
                     !(in_wait_r && ctrl.periph_clk_stop_in_wait);
      fast_en_r <= fast_tick; // fast oscillator clock never gated
    end
  end

  assign clock_output_pin_run = (clock_output_pin_sel == `CCM_CLOCK_OUTPUT_PIN_SUB) ? srcs.sub_clk :
                      (f1_tick &&
                       !(in_wait_r && ctrl.periph_clk_stop_in_wait));

  // clock pin toggles on its source; ports freeze during wait
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin_r <= 1'b0;
      port_r <= '0;
    end else begin
      if (clock_output_pin_run) begin
        clock_output_pin_r <= !clock_output_pin_r;
      end
      if (!in_wait_r) begin
        port_r <= port_out;
      end
    end
  end

  assign cpu_clk_en = cpu_clk_en_r;
  assign wdt_clk_en = wdt_clk_en_r;
  assign periph_clk_main_en = periph_en_r;
  assign fast_onchip_clk_en = fast_en_r;
  assign clock_output_pin = clock_output_pin_r;
  assign port_pins = port_r;
  assign in_wait = in_wait_r;
  assign clk_mode = mode_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  cpu_wait_stop_a: assert property (in_wait_r |=> !cpu_clk_en_r)
    else $error("cpu clock ran in wait");
  wdt_protect_a: assert property (
    in_wait_r && ctrl.count_source_protect && cpu_tick |=> wdt_clk_en_r
  ) else $error("watchdog stopped under protection");
  f1_gate_a: assert property (
    in_wait_r && ctrl.periph_clk_stop_in_wait |=> !periph_en_r
  ) else $error("f1 ran while gated");
  f1_free_a: assert property (
    f1_tick && !in_wait_r |=> periph_en_r
  ) else $error("f1 pulse lost outside wait");
  wait_entry_a: assert property (
    $rose(in_wait_r) |-> $past(wait_instr)
  ) else $error("wait entered without instruction");
  pll_decode_a: assert property (
    ctrl.pll_select && !ctrl.onchip_osc_select && !ctrl.subclock_select
    |=> mode_r == CCM_MODE_PLL
  ) else $error("pll mode not decoded");
  div8_ratio_a: assert property (
    cpu_tick && ctrl.div8_select && !ctrl.subclock_select
    |=> cur_ratio_r == `CCM_CPU_DIV8_M1
  ) else $error("divide by eight not applied");
  div16_ratio_a: assert property (
    cpu_tick && !ctrl.div8_select && !ctrl.subclock_select &&
    ctrl.cpu_divider_field == `CCM_CDIV_16
    |=> cur_ratio_r == `CCM_CPU_DIV16_M1
  ) else $error("divide by sixteen not applied");
  src_hold_a: assert property (!cpu_tick |=> $stable(cur_src_r))
    else $error("source switched mid period");
  port_hold_a: assert property (in_wait_r |=> $stable(port_r))
    else $error("port moved in wait");
  clock_output_pin_hold_a: assert property (
    in_wait_r && ctrl.periph_clk_stop_in_wait &&
    clock_output_pin_sel == `CCM_CLOCK_OUTPUT_PIN_PERIPH |=> $stable(clock_output_pin_r)
  ) else $error("clock pin toggled while gated");
  fast_pre_a: assert property (
    fast_tick |-> srcs.fast_onchip_raw_clk
  ) else $error("prescaler ticked without source");

  wait_seen_c: cover property (wait_instr ##1 in_wait_r ##[1:20] wake);
  pll_run_c: cover property (cur_src_r == CCM_SRC_PLL && cpu_tick);
  fast_run_c: cover property (cur_src_r == CCM_SRC_FAST && cpu_clk_en_r);
  wdt_wait_c: cover property (in_wait_r && wdt_clk_en_r);
endmodule

// ==== dv/ccm_top_tb.sv ====
// self-checking bench for the cpu clock mode controller
`timescale 1ns/10ps
module ccm_top_tb;
  import ccm_pkg::*;
  logic clock, rst_n, wait_instr, wake, clock_output_pin_sel;
  ccm_ctrl_s ctrl;
  ccm_srcs_s srcs;
  logic [7:0] port_out, port_pins;
  logic cpu_clk_en, wdt_clk_en, periph_clk_main_en, fast_onchip_clk_en;
  logic clock_output_pin, in_wait;
  ccm_mode_e clk_mode;
  int failures, n_tests, k, n;

  ccm_top #(.PORT_W(8)) uut (
    .clock(clock),
    .rst_n(rst_n),
    .ctrl(ctrl),
    .srcs(srcs),
    .wait_instr(wait_instr),
    .wake(wake),
    .clock_output_pin_sel(clock_output_pin_sel),
    .port_out(port_out),
    .cpu_clk_en(cpu_clk_en),
    .wdt_clk_en(wdt_clk_en),
    .periph_clk_main_en(periph_clk_main_en),
    .fast_onchip_clk_en(fast_onchip_clk_en),
    .clock_output_pin(clock_output_pin),
    .port_pins(port_pins),
    .in_wait(in_wait),
    .clk_mode(clk_mode)
  );

  // 20 mhz clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  task test_done;
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp,
             input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // builds a control word; unlisted bits stay clear
  function automatic ccm_ctrl_s mk(input int d8, f, pl, on, sb,
                                   ms, ch, fe, pr);
    ccm_ctrl_s c;
    c = '0;
    c.div8_select = d8[0];
    c.cpu_divider_field = f[1:0];
    c.pll_select = pl[0];
    c.onchip_osc_select = on[0];
    c.subclock_select = sb[0];
    c.main_clock_stop = ms[0];
    c.onchip_osc_choice = ch[0];
    c.fast_osc_enable = fe[0];
    c.fast_osc_prescaler = pr[2:0];
    return c;
  endfunction

  // cycles between two pulses of one enable; sources pulse every cycle
  task gap(input bit fast, output int cnt);
    int i;
    for (i = 0; i < 300 &&
         (fast ? fast_onchip_clk_en : cpu_clk_en) !== 1'h1; i++)
      @(posedge clock);
    @(posedge clock);
    cnt = 1;
    while (cnt < 300 &&
           (fast ? fast_onchip_clk_en : cpu_clk_en) !== 1'h1) begin
      @(posedge clock);
      cnt++;
    end
  endtask

  // apply a control word, let the old period run out, then measure
  task step(input ccm_ctrl_s c, input ccm_mode_e m, input int cg,
            input int fg);
    @(posedge clock);
    ctrl <= c;
    repeat (300) @(posedge clock);
    check("clk_mode", m, clk_mode);
    gap(1'b0, n);
    check("cpu ratio", cg, n);
    if (fg > 0) begin
      gap(1'b1, n);
      check("fast ratio", fg, n);
    end
  endtask

  // stop or restart main clock and fast oscillator together
  task osc(input logic on);
    srcs.main_clk <= on;
    srcs.fast_onchip_raw_clk <= on;
  endtask

  // enter wait, count what still runs, then wake
  task wcheck(input logic csp, input logic pcs, input logic sel);
    integer cc, wc, fc, tc; // four-state so an unknown enable is caught
    logic [7:0] pv;
    logic lp;
    @(posedge clock);
    ctrl.count_source_protect <= csp;
    ctrl.periph_clk_stop_in_wait <= pcs;
    clock_output_pin_sel <= sel;
    repeat (4) @(posedge clock);
    check("in_wait idle", 1'h0, in_wait);
    pv = port_out;
    wait_instr <= 1'h1;
    @(posedge clock);
    wait_instr <= 1'h0;
    repeat (3) @(posedge clock);
    check("in_wait", 1'h1, in_wait);
    port_out <= ~pv;
    {cc, wc, fc, tc} = '0;
    lp = clock_output_pin;
    repeat (16) begin
      @(posedge clock);
      cc += cpu_clk_en;
      wc += wdt_clk_en;
      fc += periph_clk_main_en;
      tc += (clock_output_pin !== lp);
      lp = clock_output_pin;
    end
    check("cpu in wait", 0, cc);
    check("wdt runs", csp, wc != 0);
    check("f1 runs", !pcs, fc != 0);
    check("pin runs", !sel || !pcs, tc != 0);
    check("port_pins", pv, port_pins);
    wake <= 1'h1;
    @(posedge clock);
    wake <= 1'h0;
    repeat (3) @(posedge clock);
    check("in_wait left", 1'h0, in_wait);
    gap(1'b0, n);
    check("cpu after wake", 1, n);
  endtask

  // hang guard, well past the expected run length
  initial begin
    #2000000;
    failures++;
    test_done();
  end

  initial begin
    failures = 0;
    n_tests = 0;
    rst_n = 1'h0;
    ctrl = mk(1, 0, 0, 0, 0, 0, 0, 0, 0);
    srcs = '1;
    wait_instr = 1'h0;
    wake = 1'h0;
    clock_output_pin_sel = 1'h0;
    port_out = 8'h5a;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    gap(1'b0, n);
    check("reset ratio", 8, n);
    step(mk(0, 0, 0, 0, 0, 0, 0, 0, 0), CCM_MODE_MAIN, 1, 0);
    step(mk(0, 1, 0, 0, 0, 0, 0, 0, 0), CCM_MODE_MAIN, 2, 0);
    step(mk(0, 2, 0, 0, 0, 0, 0, 0, 0), CCM_MODE_MAIN, 4, 0);
    step(mk(0, 3, 0, 0, 0, 0, 0, 0, 0), CCM_MODE_MAIN, 16, 0);
    step(mk(1, 3, 0, 0, 0, 0, 0, 0, 0), CCM_MODE_MAIN, 8, 0);
    step(mk(1, 3, 0, 0, 0, 0, 1, 1, 0), CCM_MODE_MAIN, 8, 0);
    step(mk(1, 3, 0, 1, 0, 0, 1, 1, 0), CCM_MODE_FAST_OCO, 16, 2);
    step(mk(0, 0, 0, 1, 0, 0, 1, 1, 0), CCM_MODE_FAST_OCO, 2, 2);
    step(mk(0, 3, 0, 1, 0, 0, 1, 1, 2), CCM_MODE_FAST_OCO, 64, 4);
    step(mk(0, 3, 0, 1, 0, 0, 1, 1, 6), CCM_MODE_FAST_OCO, 128, 8);
    step(mk(0, 3, 0, 1, 0, 0, 0, 1, 6), CCM_MODE_SLOW_OCO, 16, 0);
    // low power really stops main and fast sources; slow must carry on
    osc(1'h0);
    step(mk(0, 3, 0, 1, 0, 1, 0, 0, 6), CCM_MODE_SLOW_OCO_LP, 16, 0);
    osc(1'h1);
    step(mk(0, 3, 0, 1, 0, 0, 0, 1, 6), CCM_MODE_SLOW_OCO, 16, 0);
    step(mk(0, 3, 0, 1, 1, 0, 0, 1, 6), CCM_MODE_LOW_SPEED, 1, 0);
    osc(1'h0);
    step(mk(0, 3, 0, 1, 1, 1, 0, 0, 6), CCM_MODE_LOW_POWER, 1, 0);
    osc(1'h1);
    step(mk(0, 3, 0, 1, 1, 0, 0, 1, 6), CCM_MODE_LOW_SPEED, 1, 0);
    step(mk(0, 3, 0, 1, 0, 0, 0, 1, 6), CCM_MODE_SLOW_OCO, 16, 0);
    step(mk(1, 3, 0, 0, 0, 0, 0, 1, 6), CCM_MODE_MAIN, 8, 0);
    step(mk(1, 3, 1, 0, 0, 0, 0, 1, 6), CCM_MODE_PLL, 8, 0);
    // main stopped after the switch: the cpu must keep running on the pll
    srcs.main_clk <= 1'h0;
    gap(1'b0, n);
    check("pll alone", 8, n);
    srcs.main_clk <= 1'h1;
    step(mk(0, 0, 0, 0, 0, 0, 0, 1, 6), CCM_MODE_MAIN, 1, 0);
    // every mix of protection, f1 stop and pin source
    for (k = 0; k < 8; k++)
      wcheck(k[0], k[1], k[2]);
    test_done();
  end
endmodule
